// ---- logic/input_loop_holdover_fsm.sv ----
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - In locked state, a large phase error tristates the charge pump on the next clock.
// - The same large phase error clears the lock detect result.
// - The charge pump stays tristated through holdover entry, steady and zero-error exit, but not during converter release.
// - With converter holdover, switch from sensing to forcing until holdover ends.
// - Hold config bit 2 at 0x29 selects tristate-only or converter holdover.
// - Forced value is a low-pass average of samples taken only while locked.
// - Sense and force converter codes are seven bits wide.
// - Exit condition and exit behaviour are two 2-bit fields at 0x16.
// - Selectors 1 and 1 leave holdover on clear loss, a seen cycle slip and low error, no reset.
// - Zero-error exit keeps pump tristated and reacquires just after a cycle slip.
// - Selectors 0 and 0 reset dividers once loss clears, then restart.
// - Selectors 0 and 3 with converter holdover reset dividers, then raise converter impedance stepwise.
// - All loop logic runs on the common divided clock.
// - Lock asserts after two to the timer setting of low-error cycles.
// - The state machine state is readable as 3 bits at 0x82.
// - Holdover entered from locked on lock loss, signal loss or reference switch.
module input_loop_holdover_fsm (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire input_loop_pkg::byte_t regAddr,
  input wire input_loop_pkg::byte_t regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output input_loop_pkg::byte_t regRdata,
  input wire logic phaseErrBig,
  input wire logic phaseErrLow,
  input wire logic cycleSlip,
  input wire logic signalLossFlag,
  input wire logic refSwitchReq,
  input wire input_loop_pkg::code_t senseCode,
  output logic chargePumpTristate,
  output logic dividerReset,
  output logic dacForceMode,
  output input_loop_pkg::code_t dacCode,
  output input_loop_pkg::imp_t dacImpedance,
  output logic lockDetect
);
  import input_loop_pkg::*;

  state_t state;
  state_t next_state;
  logic [1:0] exitCrit;
  logic [1:0] exitAct;
  logic [4:0] lockTimer;
  logic holdUsesDac;
  logic [31:0] lockCnt;
  logic [31:0] lockLast;
  logic slipSeen;
  logic [5:0] stepCnt;
  logic stepPulse;
  logic inHold;
  exit_t exitKind;

  tune_if tif ();

  tune_averager u_avg (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tif(tif)
  );

  // Decode of the exit selectors, shared by the sequencer and its checks.
  function automatic exit_t exit_kind(input logic [1:0] crit, input logic [1:0] act,
                                      input logic useDac);
    exit_t k;
    k = EX_RESET;
    if (crit == COND_PHASE && act == ACT_SLIP) begin
      k = EX_SLIP;
    end else if (crit == COND_LOS && act == ACT_DAC && useDac) begin
      k = EX_DAC;
    end
    return k;
  endfunction : exit_kind

  assign exitKind = exit_kind(exitCrit, exitAct, holdUsesDac);
  assign inHold = (state == ST_HO_ENTRY) || (state == ST_HO_STEADY) || (state == ST_HO_EXIT)
    || (state == ST_HO_RELEASE);
  assign tif.sample = senseCode;
  assign tif.locked = lockDetect;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      exitCrit <= EXIT_CFG_RST[1:0];
      exitAct <= EXIT_CFG_RST[3:2];
      lockTimer <= LOCK_TIMER_RST;
      holdUsesDac <= HOLD_DAC_RST;
    end else if (regWrite) begin
      case (regAddr)
        ADDR_EXIT_CFG: begin
          exitCrit <= regWdata[EXIT_CRIT_LSB +: 2];
          exitAct <= regWdata[EXIT_ACT_LSB +: 2];
        end
        ADDR_LOCK_TIMER: lockTimer <= regWdata[4:0];
        ADDR_HOLD_CFG: holdUsesDac <= regWdata[HOLD_DAC_BIT];
        default: ;
      endcase
    end
  end

  // Unmapped addresses and idle cycles read as zero.
  // state readback
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      regRdata <= '0;
    end else if (regRead) begin
      case (regAddr)
        ADDR_EXIT_CFG: regRdata <= {4'h0, exitAct, exitCrit};
        ADDR_LOCK_TIMER: regRdata <= {3'h0, lockTimer};
        ADDR_HOLD_CFG: regRdata <= {5'h0, holdUsesDac, 2'h0};
        ADDR_FSM_STATE: regRdata <= {5'h0, state};
        ADDR_STATUS: regRdata <= {4'h0, dacForceMode, chargePumpTristate, inHold, lockDetect};
        ADDR_DAC_CODE: regRdata <= {1'b0, dacCode};
        default: regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // error clears lock
  // The counter is held clear in holdover so that a stale lock cannot end acquisition early.
  assign lockLast = (32'h1 << lockTimer) - 32'h1;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lockCnt <= '0;
      lockDetect <= 1'b0;
    end else if (phaseErrBig || !phaseErrLow || inHold) begin
      lockCnt <= '0;
      lockDetect <= 1'b0;
    end else if (!lockDetect) begin
      if (lockCnt == lockLast) begin
        lockDetect <= 1'b1;
      end else begin
        lockCnt <= lockCnt + 32'h1;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_INIT: next_state = ST_PRELOAD;
      ST_PRELOAD: next_state = ST_ACQUIRE;
      ST_ACQUIRE: begin
        if (lockDetect) begin
          next_state = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (!lockDetect || signalLossFlag || refSwitchReq) begin
          next_state = ST_HO_ENTRY;
        end
      end
      ST_HO_ENTRY: next_state = ST_HO_STEADY;
      ST_HO_STEADY: begin
        if (!signalLossFlag) begin
          case (exitKind)
            EX_SLIP: next_state = ST_HO_EXIT;
            EX_DAC: next_state = ST_HO_RELEASE;
            default: next_state = ST_ACQUIRE;
          endcase
        end
      end
      ST_HO_EXIT: begin
        if (signalLossFlag) begin
          next_state = ST_HO_STEADY;
        end else if (slipSeen && phaseErrLow) begin
          next_state = ST_ACQUIRE;
        end
      end
      ST_HO_RELEASE: begin
        if (stepPulse && dacImpedance == IMP_MAX) begin
          next_state = ST_ACQUIRE;
        end
      end
      default: next_state = ST_INIT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      slipSeen <= 1'b0;
    end else if (state == ST_HO_EXIT) begin
      slipSeen <= slipSeen || cycleSlip;
    end else begin
      slipSeen <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      chargePumpTristate <= 1'b0;
    end else begin
      chargePumpTristate <= (state == ST_LOCKED && phaseErrBig) || next_state == ST_HO_ENTRY
        || next_state == ST_HO_STEADY || next_state == ST_HO_EXIT;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dividerReset <= 1'b0;
    end else begin
      dividerReset <= state == ST_HO_STEADY
        && (next_state == ST_ACQUIRE || next_state == ST_HO_RELEASE);
    end
  end

  // sense to force
  // The code is frozen at entry; averaging stops anyway once lock drops.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dacForceMode <= 1'b0;
      dacCode <= '0;
    end else begin
      if (next_state == ST_ACQUIRE) begin
        dacForceMode <= 1'b0;
      end else if (state == ST_HO_ENTRY && holdUsesDac) begin
        dacForceMode <= 1'b1;
      end
      if (!dacForceMode && !(state == ST_HO_ENTRY && holdUsesDac)) begin
        dacCode <= tif.average;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stepCnt <= '0;
      stepPulse <= 1'b0;
      dacImpedance <= '0;
    end else if (state == ST_HO_RELEASE) begin
      stepPulse <= stepCnt == STEP_LAST;
      stepCnt <= (stepCnt == STEP_LAST) ? 6'h00 : stepCnt + 6'h01;
      if (stepPulse && dacImpedance != IMP_MAX) begin
        dacImpedance <= dacImpedance + 3'h1;
      end
    end else begin
      stepCnt <= '0;
      stepPulse <= 1'b0;
      dacImpedance <= '0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence releaseStart;
    state == ST_HO_STEADY && !signalLossFlag && exitKind == EX_DAC;
  endsequence
  sequence resetPulse;
    dividerReset ##1 !dividerReset;
  endsequence

  fast_tristate_a: assert property (
    state == ST_LOCKED && phaseErrBig |=> chargePumpTristate)
    else $error("pump not tristated on large phase error");
  lock_clear_a: assert property (
    phaseErrBig |=> !lockDetect ##1 state != ST_LOCKED || !lockDetect)
    else $error("lock kept after large phase error");
  hold_tristate_a: assert property (
    state == ST_HO_STEADY || state == ST_HO_EXIT |-> chargePumpTristate)
    else $error("pump active during holdover");
  force_hold_a: assert property (
    state == ST_HO_ENTRY && holdUsesDac |=> dacForceMode ##1 $stable(dacCode))
    else $error("converter not forcing a steady code");
  avg_gate_a: assert property (
    !tif.locked |=> $stable(tif.average))
    else $error("average moved while unlocked");
  slip_exit_a: assert property (
    state == ST_HO_EXIT && slipSeen && phaseErrLow && !signalLossFlag
    |=> state == ST_ACQUIRE && !dividerReset && !chargePumpTristate)
    else $error("zero error exit misbehaved");
  div_reset_a: assert property (
    state == ST_HO_STEADY && !signalLossFlag && exitKind == EX_RESET
    |=> resetPulse and state == ST_ACQUIRE)
    else $error("divider reset exit misbehaved");
  release_step_a: assert property (
    releaseStart |=> resetPulse and state == ST_HO_RELEASE && dacForceMode)
    else $error("converter release did not start");
  imp_ramp_a: assert property (
    state == ST_HO_RELEASE && stepPulse && dacImpedance != IMP_MAX
    |=> dacImpedance == $past(dacImpedance) + 3'h1)
    else $error("impedance did not step");
  lock_count_a: assert property (
    $rose(lockDetect) |-> lockCnt == lockLast && $past(phaseErrLow))
    else $error("lock asserted at wrong count");
  state_read_a: assert property (
    regRead && regAddr == ADDR_FSM_STATE |=> regRdata[2:0] == $past(state))
    else $error("state readback wrong");
  ho_entry_a: assert property (
    state == ST_LOCKED && (signalLossFlag || refSwitchReq) |=> state == ST_HO_ENTRY)
    else $error("holdover not entered");
  slip_wait_a: assert property (
    state == ST_HO_EXIT && !slipSeen |=> state != ST_ACQUIRE && chargePumpTristate)
    else $error("left slip exit before a slip");
  tristate_only_a: assert property (
    state == ST_HO_ENTRY && !holdUsesDac |=> !dacForceMode)
    else $error("converter forced in tristate-only holdover");
  div_source_a: assert property (
    dividerReset |-> state == ST_ACQUIRE || state == ST_HO_RELEASE)
    else $error("divider reset outside an exit");
  pump_release_a: assert property (
    state == ST_HO_RELEASE |-> !chargePumpTristate)
    else $error("pump still tristated during release");
endmodule : input_loop_holdover_fsm

// ---- logic/tune_averager.sv ----
`timescale 1ns/1ps
module tune_averager (
  input wire logic sys_clk,
  input wire logic resetn,
  tune_if.filt tif
);
  import input_loop_pkg::*;
  localparam int ACC_W = CODE_W + AVG_SHIFT;
  logic [ACC_W-1:0] acc;
  logic [ACC_W:0] next_acc;

  // A first-order filter keeps the forced value away from momentary noise.
  // The accumulator holds sixteen times the average, so it can never overflow.
  always_comb begin
    next_acc = {1'b0, acc} + {{(AVG_SHIFT + 1){1'b0}}, tif.sample}
      - {{(AVG_SHIFT + 1){1'b0}}, acc[ACC_W-1:AVG_SHIFT]};
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      acc <= '0;
    end else if (tif.locked) begin
      acc <= next_acc[ACC_W-1:0];
    end
  end

  assign tif.average = acc[ACC_W-1:AVG_SHIFT];
endmodule : tune_averager

// ---- shared/input_loop_pkg.sv ----
package input_loop_pkg;
  localparam int CODE_W = 7;
  typedef logic [CODE_W-1:0] code_t;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] imp_t;

  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_PRELOAD = 3'h1,
    ST_ACQUIRE = 3'h3,
    ST_LOCKED = 3'h2,
    ST_HO_ENTRY = 3'h6,
    ST_HO_STEADY = 3'h7,
    ST_HO_EXIT = 3'h5,
    ST_HO_RELEASE = 3'h4
  } state_t;

  typedef enum logic [1:0] {
    EX_RESET = 2'h0,
    EX_SLIP = 2'h1,
    EX_DAC = 2'h2
  } exit_t;

  localparam byte_t ADDR_EXIT_CFG = 8'h16;
  localparam byte_t ADDR_LOCK_TIMER = 8'h28;
  localparam byte_t ADDR_HOLD_CFG = 8'h29;
  localparam byte_t ADDR_FSM_STATE = 8'h82;
  localparam byte_t ADDR_STATUS = 8'h83;
  localparam byte_t ADDR_DAC_CODE = 8'h84;

  localparam int EXIT_CRIT_LSB = 0;
  localparam int EXIT_ACT_LSB = 2;
  localparam int HOLD_DAC_BIT = 2;
  localparam logic [1:0] COND_LOS = 2'h0;
  localparam logic [1:0] COND_PHASE = 2'h1;
  localparam logic [1:0] ACT_RESET = 2'h0;
  localparam logic [1:0] ACT_SLIP = 2'h1;
  localparam logic [1:0] ACT_DAC = 2'h3;

  localparam logic [3:0] EXIT_CFG_RST = 4'h0;
  localparam logic [4:0] LOCK_TIMER_RST = 5'h0a;
  localparam logic HOLD_DAC_RST = 1'b0;

  localparam int CLK_PERIOD_PS = 25000;
  localparam int STEP_TIME_NS = 1000;
  localparam int STEP_CYCLES = (STEP_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [5:0] STEP_LAST = 6'(STEP_CYCLES - 1);
  localparam imp_t IMP_MAX = 3'h7;
  localparam int AVG_SHIFT = 4;
endpackage : input_loop_pkg

// ---- shared/tune_if.sv ----
`timescale 1ns/1ps
interface tune_if;
  import input_loop_pkg::*;
  code_t sample;
  logic locked;
  code_t average;
  modport ctl (output sample, output locked, input average);
  modport filt (input sample, input locked, output average);
endinterface : tune_if

// ---- test/input_loop_holdover_fsm_tb_top.sv ----
`timescale 1ns/1ps
module input_loop_holdover_fsm_tb_top;
  import input_loop_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  byte_t regAddr = 8'h00;
  byte_t regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic refGood = 1'b0;
  logic bigCmd = 1'b0;
  logic slipCmd = 1'b0;
  logic switchCmd = 1'b0;
  code_t tuneLevel = 7'h55;
  byte_t regRdata;
  logic phaseErrBig, phaseErrLow, cycleSlip, signalLossFlag, refSwitchReq;
  logic chargePumpTristate, dividerReset, dacForceMode, lockDetect;
  code_t senseCode, dacCode, held;
  imp_t dacImpedance;
  int failures = 0;
  int n_tests = 0;
  int resets = 0;
  int n, m, r0;
  byte_t cfgs [3] = '{8'h00, 8'h0a, 8'h0c};

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (dividerReset === 1'b1) resets++;
  end

  input_loop_holdover_fsm dut_u (.sys_clk, .resetn, .regAddr, .regWdata, .regWrite,
    .regRead, .regRdata, .phaseErrBig, .phaseErrLow, .cycleSlip, .signalLossFlag,
    .refSwitchReq, .senseCode, .chargePumpTristate, .dividerReset, .dacForceMode,
    .dacCode, .dacImpedance, .lockDetect);
  loop_partner partner_u (.sys_clk, .refGood, .bigCmd, .slipCmd, .switchCmd, .tuneLevel,
    .dividerReset, .phaseErrBig, .phaseErrLow, .cycleSlip, .signalLossFlag,
    .refSwitchReq, .senseCode);

  task automatic chk(input string what, input byte_t exp, input byte_t got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input byte_t a, input byte_t d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rdchk(input string what, input byte_t a, input byte_t exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 chk(what, exp, regRdata);
  endtask : rdchk

  function automatic logic pick(input int k);
    case (k)
      0: return lockDetect;
      1: return chargePumpTristate;
      2: return dividerReset;
      default: return dacForceMode;
    endcase
  endfunction : pick

  task automatic waitHi(input string what, input int k, input int lim);
    int c;
    c = 0;
    while (pick(k) !== 1'b1 && c < lim) begin
      @(posedge sys_clk);
      #1;
      c++;
    end
    chk(what, 8'h01, {7'h0, pick(k)});
  endtask : waitHi

  task automatic give_verdict;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // The whole run is about a thousand cycles, so this 20000-cycle bound only trips on a hang.
  initial begin
    #(25 * 20000);
    failures++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rdchk("exit cfg", ADDR_EXIT_CFG, 8'h00);
    rdchk("timer", ADDR_LOCK_TIMER, 8'h0a);
    rdchk("hold cfg", ADDR_HOLD_CFG, 8'h00);
    wr(ADDR_FSM_STATE, 8'hff);
    wr(8'ha5, 8'h06);
    rdchk("state", ADDR_FSM_STATE, 8'(ST_ACQUIRE));
    rdchk("unmapped", 8'h40, 8'h00);
    wr(ADDR_EXIT_CFG, 8'h0f);
    rdchk("exit cfg", ADDR_EXIT_CFG, 8'h0f);
    chk("code unlocked", 8'h00, {1'b0, dacCode});
    wr(ADDR_LOCK_TIMER, 8'h02);
    @(posedge sys_clk) refGood <= 1'b1;
    #1;
    n = 0;
    m = 0;
    while (lockDetect !== 1'b1 && m < 100) begin
      if (phaseErrLow === 1'b1) n++;
      @(posedge sys_clk);
      #1;
      m++;
    end
    chk("lock edges", 8'(1 << 2), 8'(n));
    rdchk("state", ADDR_FSM_STATE, 8'(ST_LOCKED));
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_EXIT_CFG, cfgs[i]);
      waitHi("relock", 0, 200);
      r0 = resets;
      @(posedge sys_clk);
      bigCmd <= (i == 0);
      switchCmd <= (i == 1);
      refGood <= (i == 1);
      waitHi("tristate", 1, 4);
      if (i == 0) chk("lock cleared", 8'h00, {7'h0, lockDetect});
      @(posedge sys_clk);
      bigCmd <= 1'b0;
      switchCmd <= 1'b0;
      if (i != 1) begin
        n = 0;
        repeat (20) begin
          @(posedge sys_clk);
          #1;
          if (chargePumpTristate !== 1'b1) n++;
        end
        chk("pump held", 8'h00, 8'(n));
        rdchk("state", ADDR_FSM_STATE, 8'(ST_HO_STEADY));
      end
      @(posedge sys_clk) refGood <= 1'b1;
      repeat (12) @(posedge sys_clk);
      #1 chk("div pulses", 8'h01, 8'(resets - r0));
      chk("pump free", 8'h00, {7'h0, chargePumpTristate});
    end
    wr(ADDR_EXIT_CFG, 8'h05);
    waitHi("relock", 0, 200);
    r0 = resets;
    @(posedge sys_clk) refGood <= 1'b0;
    waitHi("tristate", 1, 4);
    repeat (5) @(posedge sys_clk);
    refGood <= 1'b1;
    repeat (30) @(posedge sys_clk);
    rdchk("state", ADDR_FSM_STATE, 8'(ST_HO_EXIT));
    chk("pump wait", 8'h01, {7'h0, chargePumpTristate});
    rdchk("status", ADDR_STATUS, 8'h06);
    @(posedge sys_clk) slipCmd <= 1'b1;
    @(posedge sys_clk) slipCmd <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 chk("pump slip", 8'h00, {7'h0, chargePumpTristate});
    chk("no div reset", 8'h00, 8'(resets - r0));
    wr(ADDR_EXIT_CFG, 8'h0c);
    wr(ADDR_HOLD_CFG, 8'h04);
    rdchk("hold cfg", ADDR_HOLD_CFG, 8'h04);
    waitHi("relock", 0, 200);
    repeat (300) @(posedge sys_clk);
    #1 chk("code avg", 8'h55, {1'b0, dacCode});
    rdchk("code read", ADDR_DAC_CODE, 8'h55);
    @(posedge sys_clk) refGood <= 1'b0;
    waitHi("force", 3, 6);
    held = dacCode;
    @(posedge sys_clk) tuneLevel <= 7'h10;
    repeat (40) @(posedge sys_clk);
    #1 chk("code held", {1'b0, held}, {1'b0, dacCode});
    @(posedge sys_clk) refGood <= 1'b1;
    waitHi("release", 2, 8);
    for (int k = 0; k < 8; k++) begin
      repeat (k == 0 ? 20 : 40) @(posedge sys_clk);
      #1 chk("impedance", 8'(k), {5'h0, dacImpedance});
    end
    chk("pump release", 8'h00, {7'h0, chargePumpTristate});
    chk("force kept", 8'h01, {7'h0, dacForceMode});
    repeat (40) @(posedge sys_clk);
    #1 chk("force off", 8'h00, {7'h0, dacForceMode});
    chk("impedance", 8'h00, {5'h0, dacImpedance});
    give_verdict();
  end
endmodule : input_loop_holdover_fsm_tb_top

// ---- test/loop_partner.sv ----
`timescale 1ns/1ps
module loop_partner (
  input wire logic sys_clk,
  input wire logic refGood,
  input wire logic bigCmd,
  input wire logic slipCmd,
  input wire logic switchCmd,
  input wire input_loop_pkg::code_t tuneLevel,
  input wire logic dividerReset,
  output logic phaseErrBig = 1'b0,
  output logic phaseErrLow = 1'b0,
  output logic cycleSlip = 1'b0,
  output logic signalLossFlag = 1'b1,
  output logic refSwitchReq = 1'b0,
  output input_loop_pkg::code_t senseCode = 7'h00
);
  import input_loop_pkg::*;
  logic lastGood = 1'b0;
  logic drift = 1'b0;
  // After an outage the phases stay apart until a slip or a divider restart.
  always @(posedge sys_clk) begin
    lastGood <= refGood;
    if (slipCmd || dividerReset) begin
      drift <= 1'b0;
    end else if (lastGood && !refGood) begin
      drift <= 1'b1;
    end
    signalLossFlag <= !refGood;
    phaseErrBig <= bigCmd;
    phaseErrLow <= refGood && !drift && !bigCmd;
    cycleSlip <= slipCmd;
    refSwitchReq <= switchCmd;
    senseCode <= tuneLevel;
  end
endmodule : loop_partner
